// ==== rtl/bps_map.svh ====
// address map, field positions and reset values of the bank pointer and stack block
`ifndef BPS_MAP_SVH
`define BPS_MAP_SVH
// ***********************************************************************
// register offsets (8-bit, bank independent) and the 12-bit linear address of the select register
// ***********************************************************************
`define BPS_OFF_BANK_GROUP  8'hFD
`define BPS_OFF_SP_HIGH     8'hFE
`define BPS_OFF_SP_LOW      8'hFF
`define BPS_LIN_BANK_GROUP  12'h0FD
// ***********************************************************************
// fields and reset values
// ***********************************************************************
`define BPS_GROUP_MSB       7
`define BPS_GROUP_LSB       4
`define BPS_BANK_MSB        3
`define BPS_BANK_LSB        0
`define BPS_BANK_GROUP_RST  8'h00
`define BPS_SP_RST          8'h00
`define BPS_LOW_LIMIT       8'h0F
`define BPS_GROUP_F         4'hF
`define BPS_PORT_LIMIT      8'h03
`define BPS_BANK_D          4'hD
`define BPS_BANK_F          4'hF
`define BPS_RAM_1K          2'h1
`define BPS_RAM_512         2'h2
`endif

// ==== rtl/bps_pkg.sv ====
// types shared by the bank pointer and stack block
`default_nettype none
package bps_pkg;
   // ***********************************************************************
   // stack operation kinds
   // ***********************************************************************
   typedef enum logic [2:0] {
      BPS_OP_NONE  = 3'h0,
      BPS_OP_PUSH  = 3'h1,
      BPS_OP_POP   = 3'h2,
      BPS_OP_CALL  = 3'h3,
      BPS_OP_INTR  = 3'h4
   } bps_op_t;

   // sequencer states, gray along idle, step, step2, step3
   typedef enum logic [1:0] {
      BPS_ST_IDLE  = 2'b00,
      BPS_ST_S1    = 2'b01,
      BPS_ST_S2    = 2'b11,
      BPS_ST_S3    = 2'b10
   } bps_state_t;

   // one stack memory access request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic        shadow;
      logic [7:0]  wdata;
   } bps_mem_req_t;
endpackage : bps_pkg
`default_nettype wire

// ==== rtl/bps_addr_map.sv ====
// maps a stack pointer to a linear RAM address with shadow flag
`timescale 1ns/10ps
`default_nettype none
`include "bps_map.svh"
module bps_addr_map
(
   // pointer and mode
   input  wire logic [15:0] i_sp,
   input  wire logic        i_wide,
   input  wire logic [1:0]  i_ram_size,
   // mapped address
   output logic [11:0]      o_addr,
   output logic             o_shadow
);
   logic [1:0] bank;

   // ***********************************************************************
   // bank from the high byte, masked by RAM size
   // ***********************************************************************
   always_comb
   begin
      bank = 2'h0;
      if (i_wide)
      begin
         if (i_ram_size == `BPS_RAM_512)
            bank = {1'b0, i_sp[8]};
         else if (i_ram_size == `BPS_RAM_1K)
            bank = i_sp[9:8];
         else
            bank = i_sp[9:8];
      end
   end

   // group and register come from the low byte; wide mode shadows control/port slots
   assign o_addr   = {2'h0, bank, i_sp[7:0]};
   assign o_shadow = i_wide && ((i_sp[7:4] == `BPS_GROUP_F) ||
                                (i_sp[7:0] <= `BPS_PORT_LIMIT));
endmodule : bps_addr_map
`default_nettype wire

// ==== rtl/bps_regs.sv ====
// bank/group select and stack pointer registers with push/pop sequencer
//
// Contract
// - upper nibble picks 16-byte working group
// - lower nibble is the expanded bank pointer
// - zero bank selects normal register file
// - nonzero bank replaces lowest sixteen addresses
// - select register at FDh and 0FDh
// - option bit picks 8- or 16-bit stack
// - narrow mode: high byte is spare storage
// - narrow stack stays in bank 0
// - wide stack spans all RAM
// - push decrements, then writes
// - pop reads, then increments
// - pointer marks the lowest occupied address
// - call pushes the program counter
// - interrupt pushes counter and flags
// - 1K RAM ignores upper six high bits
// - 512 RAM ignores upper seven high bits
// - wide map: bank, group, register fields
// - wide stack hits shadow RAM, not controls
`timescale 1ns/10ps
`default_nettype none
`include "bps_map.svh"
module bps_regs
(
   // clock and reset
   input  wire logic               i_mclk,
   input  wire logic               i_sys_rst,
   // option and part straps (static nonvolatile bits)
   input  wire logic               i_opt_wide_stack,
   input  wire logic [1:0]         i_ram_size,
   // register port
   input  wire logic [7:0]         i_reg_addr,
   input  wire logic [7:0]         i_reg_wdata,
   input  wire logic               i_reg_wr,
   input  wire logic               i_reg_rd,
   output logic [7:0]              o_reg_rdata,
   // core operand mapping
   input  wire logic [3:0]         i_work_reg,
   input  wire logic [7:0]         i_dir_addr,
   input  wire logic               i_instr_start,
   output logic [11:0]             o_work_addr,
   output logic [11:0]             o_dir_addr,
   // stack operation request
   input  wire bps_pkg::bps_op_t   i_op,
   input  wire logic [15:0]        i_pc,
   input  wire logic [7:0]         i_flags,
   input  wire logic [7:0]         i_push_data,
   output logic                    o_busy,
   // stack memory side
   output bps_pkg::bps_mem_req_t   o_mem,
   input  wire logic [7:0]         i_mem_rdata,
   output logic [7:0]              o_pop_data,
   output logic                    o_pop_valid
);
   // ***********************************************************************
   // storage
   // ***********************************************************************
   logic [7:0]            bank_group_select_r;
   logic [7:0]            active_sel_r;
   logic [7:0]            stack_ptr_high_or_spare_r;
   logic [7:0]            stack_ptr_low_r;
   logic                  wide_r;
   bps_pkg::bps_state_t   state_r;
   bps_pkg::bps_state_t   state_nxt;
   bps_pkg::bps_op_t      op_r;
   logic                  pop_wait_r;
   logic [15:0]           sp_cur;
   logic [15:0]           sp_dec;
   logic [15:0]           sp_inc;
   logic [11:0]           map_addr;
   logic                  map_shadow;
   logic                  do_push;
   logic                  do_pop;
   logic [7:0]            push_byte;
   logic [3:0]            cur_bank;
   logic [3:0]            cur_group;

   // full pointer; narrow mode ignores the high byte entirely
   assign sp_cur = wide_r ? {stack_ptr_high_or_spare_r, stack_ptr_low_r}
                          : {8'h00, stack_ptr_low_r};
   assign sp_dec = sp_cur - 16'h0001;
   assign sp_inc = sp_cur + 16'h0001;

   // ***********************************************************************
   // option bit is caught after reset release, never under the async reset
   // ***********************************************************************
   logic opt_taken_r;
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         wide_r      <= 1'b0;
         opt_taken_r <= 1'b0;
      end
      else if (!opt_taken_r)
      begin
         wide_r      <= i_opt_wide_stack;
         opt_taken_r <= 1'b1;
      end
   end

   // ***********************************************************************
   // sequencer: push/call/intr step through bytes, pop reads then bumps
   // ***********************************************************************
   always_comb
   begin
      state_nxt = state_r;
      do_push   = 1'b0;
      do_pop    = 1'b0;
      push_byte = 8'h00;
      case (state_r)
         bps_pkg::BPS_ST_IDLE:
         begin
            if (i_op == bps_pkg::BPS_OP_PUSH)
            begin
               do_push   = 1'b1;
               push_byte = i_push_data;
            end
            else if (i_op == bps_pkg::BPS_OP_POP)
               do_pop = 1'b1;
            else if (i_op == bps_pkg::BPS_OP_CALL || i_op == bps_pkg::BPS_OP_INTR)
            begin
               do_push   = 1'b1;
               push_byte = i_pc[7:0];
               state_nxt = bps_pkg::BPS_ST_S1;
            end
         end
         bps_pkg::BPS_ST_S1:
         begin
            do_push   = 1'b1;
            push_byte = i_pc[15:8];
            state_nxt = (op_r == bps_pkg::BPS_OP_INTR) ? bps_pkg::BPS_ST_S2
                                                       : bps_pkg::BPS_ST_IDLE;
         end
         bps_pkg::BPS_ST_S2:
         begin
            do_push   = 1'b1;
            push_byte = i_flags;
            state_nxt = bps_pkg::BPS_ST_IDLE;
         end
         default:
            state_nxt = bps_pkg::BPS_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_r <= bps_pkg::BPS_ST_IDLE;
         op_r    <= bps_pkg::BPS_OP_NONE;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r == bps_pkg::BPS_ST_IDLE)
            op_r <= i_op;
      end
   end

   // ***********************************************************************
   // address mapping of the access; push uses the decremented pointer
   // ***********************************************************************
   bps_addr_map u_map
   (
      .i_sp       (do_push ? sp_dec : sp_cur),
      .i_wide     (wide_r),
      .i_ram_size (i_ram_size),
      .o_addr     (map_addr),
      .o_shadow   (map_shadow)
   );

   // registered memory request, one byte per cycle
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         o_mem <= '0;
      else
      begin
         o_mem.wr     <= do_push;
         o_mem.rd     <= do_pop;
         o_mem.addr   <= map_addr;
         o_mem.shadow <= map_shadow;
         o_mem.wdata  <= push_byte;
      end
   end

   // pop data and valid arrive two cycles after the read request
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         pop_wait_r  <= 1'b0;
         o_pop_valid <= 1'b0;
         o_pop_data  <= 8'h00;
      end
      else
      begin
         pop_wait_r  <= o_mem.rd;
         o_pop_valid <= pop_wait_r;
         if (pop_wait_r)
            o_pop_data <= i_mem_rdata;
      end
   end

   // busy while a multi-byte push is in flight
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         o_busy <= 1'b0;
      else
         o_busy <= (state_nxt != bps_pkg::BPS_ST_IDLE);
   end

   // ***********************************************************************
   // stack pointer bytes: stack moves override a same-cycle software write
   // ***********************************************************************
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         stack_ptr_low_r           <= `BPS_SP_RST;
         stack_ptr_high_or_spare_r <= `BPS_SP_RST;
      end
      else if (do_push)
      begin
         stack_ptr_low_r <= sp_dec[7:0];
         if (wide_r)
            stack_ptr_high_or_spare_r <= sp_dec[15:8];
      end
      else if (do_pop)
      begin
         stack_ptr_low_r <= sp_inc[7:0];
         if (wide_r)
            stack_ptr_high_or_spare_r <= sp_inc[15:8];
      end
      else if (i_reg_wr)
      begin
         if (i_reg_addr == `BPS_OFF_SP_LOW)
            stack_ptr_low_r <= i_reg_wdata;
         else if (i_reg_addr == `BPS_OFF_SP_HIGH)
            stack_ptr_high_or_spare_r <= i_reg_wdata;
      end
   end

   // ***********************************************************************
   // bank/group select, and the copy that the addressing really uses
   // ***********************************************************************
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         bank_group_select_r <= `BPS_BANK_GROUP_RST;
      else if (i_reg_wr && i_reg_addr == `BPS_OFF_BANK_GROUP)
         bank_group_select_r <= i_reg_wdata;
   end

   // the copy updates only on an instruction boundary, so the writer itself is unaffected
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         active_sel_r <= `BPS_BANK_GROUP_RST;
      else if (i_instr_start)
         active_sel_r <= bank_group_select_r;
   end

   assign cur_group = active_sel_r[`BPS_GROUP_MSB:`BPS_GROUP_LSB];
   assign cur_bank  = active_sel_r[`BPS_BANK_MSB:`BPS_BANK_LSB];

   // ***********************************************************************
   // operand mapping: working register and 8-bit direct address
   // ***********************************************************************
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_work_addr <= 12'h000;
         o_dir_addr  <= 12'h000;
      end
      else
      begin
         // working register sits in the chosen 16-byte group of bank 0 space
         o_work_addr <= {4'h0, cur_group, i_work_reg};
         if (i_dir_addr >= 8'hF0)
            o_dir_addr <= {4'h0, i_dir_addr};                     // control space is fixed
         else if (cur_bank == 4'h0)
            o_dir_addr <= {4'h0, i_dir_addr};
         else if (i_dir_addr <= `BPS_LOW_LIMIT)
            o_dir_addr <= {cur_bank, i_dir_addr};
         else
            o_dir_addr <= {4'h0, i_dir_addr};
      end
   end

   // ***********************************************************************
   // register read port, data one cycle after the strobe
   // ***********************************************************************
   always_ff @(posedge i_mclk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         o_reg_rdata <= 8'h00;
      else if (i_reg_rd)
      begin
         if (i_reg_addr == `BPS_OFF_BANK_GROUP)
            o_reg_rdata <= bank_group_select_r;
         else if (i_reg_addr == `BPS_OFF_SP_HIGH)
            o_reg_rdata <= stack_ptr_high_or_spare_r;
         else if (i_reg_addr == `BPS_OFF_SP_LOW)
            o_reg_rdata <= stack_ptr_low_r;
         else
            o_reg_rdata <= 8'h00;                                 // unmapped reads zero
      end
      else
         o_reg_rdata <= 8'h00;
   end
endmodule : bps_regs
`default_nettype wire

// ==== verif/bps_regs_sva.sv ====
// assertion checker for the bank pointer and stack register block
`timescale 1ns/10ps
`default_nettype none
module bps_regs_sva
(
   // clock and reset
   input  wire logic                  i_mclk,
   input  wire logic                  i_sys_rst,
   // watched ports
   input  wire logic                  i_opt_wide_stack,
   input  wire logic                  i_reg_rd,
   input  wire logic [7:0]            o_reg_rdata,
   input  wire logic [3:0]            i_work_reg,
   input  wire logic [11:0]           o_work_addr,
   input  wire bps_pkg::bps_op_t      i_op,
   input  wire logic                  o_busy,
   input  wire bps_pkg::bps_mem_req_t o_mem,
   input  wire logic                  o_pop_valid
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);

   // ***********************************************************************
   // accepted requests and memory steps
   // ***********************************************************************
   // a request only counts when the sequencer is free to take it
   logic go_push;
   logic go_pop;
   logic go_call;
   logic go_intr;
   assign go_push = (i_op == bps_pkg::BPS_OP_PUSH) && !o_busy;
   assign go_pop  = (i_op == bps_pkg::BPS_OP_POP) && !o_busy;
   assign go_call = (i_op == bps_pkg::BPS_OP_CALL) && !o_busy;
   assign go_intr = (i_op == bps_pkg::BPS_OP_INTR) && !o_busy;
   sequence s_wr;
      o_mem.wr && !o_mem.rd;
   endsequence
   sequence s_rd;
      o_mem.rd && !o_mem.wr;
   endsequence

   // ***********************************************************************
   // properties
   // ***********************************************************************
   a_push_one_write: assert property (go_push |=> s_wr)
      else $error("push did not write memory next cycle");
   a_pop_read_valid: assert property (go_pop |=> s_rd ##2 o_pop_valid)
      else $error("pop read or data valid timing wrong");
   a_call_two_writes: assert property (go_call |=> s_wr [*2])
      else $error("call did not write two bytes");
   a_busy_call_span: assert property (go_call |=> o_busy ##1 !o_busy)
      else $error("busy span of a call is wrong");
   a_intr_three_writes: assert property (go_intr |=> s_wr [*3])
      else $error("interrupt did not write three bytes");
   a_rdata_idle_zero: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
      else $error("read data not zero outside read slot");
   a_narrow_bank_zero: assert property ((o_mem.wr || o_mem.rd) && !i_opt_wide_stack
      |-> o_mem.addr[11:8] == 4'h0 && !o_mem.shadow)
      else $error("narrow stack access left bank zero");
   a_steps_descend: assert property (o_mem.wr && $past(o_mem.wr) && !i_opt_wide_stack
      |-> o_mem.addr[7:0] == $past(o_mem.addr[7:0]) - 8'h01)
      else $error("successive stack writes not descending");
   a_work_reg_field: assert property (!$past(i_sys_rst)
      |-> o_work_addr[3:0] == $past(i_work_reg) && o_work_addr[11:8] == 4'h0)
      else $error("working register address field wrong");
endmodule : bps_regs_sva

bind bps_regs bps_regs_sva u_sva
(
   .i_mclk           (i_mclk),
   .i_sys_rst        (i_sys_rst),
   .i_opt_wide_stack (i_opt_wide_stack),
   .i_reg_rd         (i_reg_rd),
   .o_reg_rdata      (o_reg_rdata),
   .i_work_reg       (i_work_reg),
   .o_work_addr      (o_work_addr),
   .i_op             (i_op),
   .o_busy           (o_busy),
   .o_mem            (o_mem),
   .o_pop_valid      (o_pop_valid)
);
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking testbench for the bank pointer and stack register block
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic                  i_mclk;
   logic                  i_sys_rst;
   logic                  i_opt_wide_stack;
   logic [1:0]            i_ram_size;
   logic [7:0]            i_reg_addr;
   logic [7:0]            i_reg_wdata;
   logic                  i_reg_wr;
   logic                  i_reg_rd;
   logic [7:0]            o_reg_rdata;
   logic [3:0]            i_work_reg;
   logic [7:0]            i_dir_addr;
   logic                  i_instr_start;
   logic [11:0]           o_work_addr;
   logic [11:0]           o_dir_addr;
   bps_pkg::bps_op_t      i_op;
   logic [15:0]           i_pc;
   logic [7:0]            i_flags;
   logic [7:0]            i_push_data;
   logic                  o_busy;
   bps_pkg::bps_mem_req_t o_mem;
   logic [7:0]            i_mem_rdata;
   logic [7:0]            o_pop_data;
   logic                  o_pop_valid;
   int                    failures;
   int                    checks;
   bps_pkg::bps_mem_req_t seen [3];

   bps_regs dut
   (
      .i_mclk (i_mclk), .i_sys_rst (i_sys_rst), .i_opt_wide_stack (i_opt_wide_stack),
      .i_ram_size (i_ram_size), .i_reg_addr (i_reg_addr), .i_reg_wdata (i_reg_wdata),
      .i_reg_wr (i_reg_wr), .i_reg_rd (i_reg_rd), .o_reg_rdata (o_reg_rdata),
      .i_work_reg (i_work_reg), .i_dir_addr (i_dir_addr), .i_instr_start (i_instr_start),
      .o_work_addr (o_work_addr), .o_dir_addr (o_dir_addr), .i_op (i_op), .i_pc (i_pc),
      .i_flags (i_flags), .i_push_data (i_push_data), .o_busy (o_busy), .o_mem (o_mem),
      .i_mem_rdata (i_mem_rdata), .o_pop_data (o_pop_data), .o_pop_valid (o_pop_valid)
   );

   // ***********************************************************************
   // bench tasks
   // ***********************************************************************
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic give_verdict;
      if (failures == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // the option is only latched just after reset, so reset per mode; ram size is used live
   task automatic do_reset(input logic wide, input logic [1:0] size);
      i_opt_wide_stack <= wide;
      i_ram_size <= size;
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      repeat (2) @(posedge i_mclk);
   endtask : do_reset

   task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_mclk);
      i_reg_addr <= addr;
      i_reg_wdata <= data;
      i_reg_wr <= 1'b1;
      @(posedge i_mclk);
      i_reg_wr <= 1'b0;
   endtask : reg_wr

   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      @(posedge i_mclk);
      i_reg_addr <= addr;
      i_reg_rd <= 1'b1;
      @(posedge i_mclk);
      i_reg_rd <= 1'b0;
      #1;
      check(o_reg_rdata, exp);
   endtask : rd_chk

   // operands change at an edge; select copy follows only a start pulse
   task automatic settle(input logic start, input logic [3:0] wreg, input logic [7:0] daddr);
      @(posedge i_mclk);
      i_instr_start <= start;
      i_work_reg <= wreg;
      i_dir_addr <= daddr;
      @(posedge i_mclk);
      i_instr_start <= 1'b0;
      repeat (2) @(posedge i_mclk);
      #1;
   endtask : settle

   // one stack request, then n memory steps captured
   task automatic stack_op(input bps_pkg::bps_op_t op, input int n);
      @(posedge i_mclk);
      i_op <= op;
      @(posedge i_mclk);
      i_op <= bps_pkg::BPS_OP_NONE;
      // the first step already stands after the edge that takes the request
      for (int k = 0; k < n; k++)
      begin
         if (k > 0)
            @(posedge i_mclk);
         #1;
         seen[k] = o_mem;
      end
   endtask : stack_op

   task automatic mem_chk(input int k, input logic [11:0] a, input logic sh, input logic [7:0] d);
      check(seen[k], {1'b1, 1'b0, a, sh, d});
   endtask : mem_chk

   // ***********************************************************************
   // clock, watchdog and test sequence
   // ***********************************************************************
   initial
   begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end

   // whole run is under a hundred cycles, so 20 us means a hang
   initial
   begin
      #20000;
      failures++;
      give_verdict();
   end

   initial
   begin
      {i_sys_rst, i_opt_wide_stack, i_ram_size, i_reg_addr, i_reg_wdata} = '0;
      {i_reg_wr, i_reg_rd, i_work_reg, i_dir_addr, i_instr_start} = '0;
      {i_pc, i_flags, i_push_data} = '0;
      i_op = bps_pkg::BPS_OP_NONE;
      i_mem_rdata = 8'h5A;
      failures = 0;
      checks = 0;
      do_reset(1'b0, 2'h1);
      rd_chk(8'hFD, 8'h00);
      rd_chk(8'hFE, 8'h00);
      rd_chk(8'hFF, 8'h00);
      reg_wr(8'h20, 8'h33);
      rd_chk(8'hFD, 8'h00);
      reg_wr(8'hFD, 8'h7D);
      settle(1'b0, 4'h3, 8'h05);
      check(o_work_addr, 12'h003);
      settle(1'b1, 4'h3, 8'h05);
      check(o_work_addr, 12'h073);
      check(o_dir_addr, 12'hD05);
      settle(1'b0, 4'h3, 8'h20);
      check(o_dir_addr, 12'h020);
      reg_wr(8'hFD, 8'h00);
      settle(1'b1, 4'h3, 8'h05);
      check(o_dir_addr, 12'h005);
      reg_wr(8'hFF, 8'h40);
      reg_wr(8'hFE, 8'hA5);
      i_push_data <= 8'hC3;
      stack_op(bps_pkg::BPS_OP_PUSH, 1);
      mem_chk(0, 12'h03F, 1'b0, 8'hC3);
      rd_chk(8'hFF, 8'h3F);
      rd_chk(8'hFE, 8'hA5);
      stack_op(bps_pkg::BPS_OP_POP, 1);
      check({seen[0].rd, seen[0].wr, seen[0].addr}, {2'h2, 12'h03F});
      repeat (2) @(posedge i_mclk);
      #1;
      check({o_pop_valid, o_pop_data}, {1'b1, 8'h5A});
      rd_chk(8'hFF, 8'h40);
      i_pc <= 16'h1234;
      i_flags <= 8'h81;
      stack_op(bps_pkg::BPS_OP_CALL, 2);
      mem_chk(0, 12'h03F, 1'b0, 8'h34);
      mem_chk(1, 12'h03E, 1'b0, 8'h12);
      stack_op(bps_pkg::BPS_OP_INTR, 3);
      mem_chk(0, 12'h03D, 1'b0, 8'h34);
      mem_chk(1, 12'h03C, 1'b0, 8'h12);
      mem_chk(2, 12'h03B, 1'b0, 8'h81);
      rd_chk(8'hFF, 8'h3B);
      do_reset(1'b1, 2'h1);
      reg_wr(8'hFE, 8'hFE);
      reg_wr(8'hFF, 8'h00);
      stack_op(bps_pkg::BPS_OP_PUSH, 1);
      mem_chk(0, 12'h1FF, 1'b1, 8'hC3);
      rd_chk(8'hFE, 8'hFD);
      rd_chk(8'hFF, 8'hFF);
      do_reset(1'b1, 2'h2);
      reg_wr(8'hFE, 8'h03);
      reg_wr(8'hFF, 8'h10);
      stack_op(bps_pkg::BPS_OP_PUSH, 1);
      mem_chk(0, 12'h10F, 1'b0, 8'hC3);
      give_verdict();
   end
endmodule : tb
`default_nettype wire
